// ### core/eeprom_host_pkg.sv
package eeprom_host_pkg;
    // device geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // system clock
    localparam int SYS_PERIOD_NS = 10;

    // pin timing, each in its own unit
    localparam int STROBE_MIN_MS = 9;
    localparam int STROBE_MAX_MS = 15;
    localparam int CHIP_ERASE_MS = 10;
    localparam int POST_WRITE_WAIT_US = 40;
    localparam int WRITE_SETUP_NS = 150;
    localparam int WRITE_HOLD_NS = 100;
    localparam int ADDRESS_ACCESS_DELAY_NS = 250;
    localparam int SELECT_ACCESS_DELAY_NS = 250;
    localparam int OUTPUT_FLOAT_NS = 80;

    // cycle counts: least times round up, longest time rounds down
    localparam int STROBE_MIN_CYC = (STROBE_MIN_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int STROBE_MAX_CYC = (STROBE_MAX_MS * 1000000) / SYS_PERIOD_NS;
    localparam int CHIP_ERASE_CYC = (CHIP_ERASE_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int POST_WRITE_WAIT_CYC = (POST_WRITE_WAIT_US * 1000 + SYS_PERIOD_NS - 1)
        / SYS_PERIOD_NS;
    localparam int WRITE_SETUP_CYC = (WRITE_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int WRITE_HOLD_CYC = (WRITE_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int ACCESS_CYC = (ADDRESS_ACCESS_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int FLOAT_CYC = (OUTPUT_FLOAT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    // wait from gate low to sampling: access plus synchroniser plus margin
    localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_STAGES + 1;

    localparam int CNT_W = 24;

    // values after reset
    localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // host operations
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_ERASE,
        OP_CHIP_ERASE
    } op_t;

    // one request from the user side
    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    // pins driven towards the memory
    typedef struct packed {
        logic select_n;
        logic gate_n;
        logic strobe_n;
        logic gate_high_volt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } pins_t;
endpackage

// ### core/eeprom_pin_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for the data pins coming back from the memory
module eeprom_pin_sync #(
    parameter int WIDTH = 8
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic en,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1; // read only by stage two
    logic [WIDTH-1:0] stage2;

    // both stages frozen with the enable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else if (en) begin
            stage1 <= pin_in;
            stage2 <= stage1;
        end
    end

    assign pin_sync = stage2;
endmodule

// ### core/eeprom_host.sv
`timescale 1ns/1ns
// Operation
// - erase a byte before writing it
// - erase: address, data all ones, strobe low
// - gate stays high during erase and write
// - strobe low between 9 and 15 ms
// - repeat strobe with the data to store
// - pins stable through the whole programming time
// - data all ones during chip erase
// - select decoded, gate follows read strobe
// - wait 40 us after each write cycle
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = STROBE_MIN_CYC,
    parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic en,
    // user request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire eeprom_host_pkg::cmd_t cmd,
    // user answer
    output logic done,
    output logic [eeprom_host_pkg::DATA_W-1:0] rd_data,
    output logic busy,
    // memory pins
    output eeprom_host_pkg::pins_t pins,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] dq_in
);
    import eeprom_host_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RECOVER,
        ST_RD_WAIT,
        ST_RD_FLOAT
    } state_t;

    state_t state, next_state; // sequencer
    cmd_t req, next_req; // latched request
    logic erase_phase, next_erase_phase; // erase step: first half of a write, or the whole of a byte erase
    logic [CNT_W-1:0] cnt, next_cnt; // down counter of the current step
    pins_t next_pins; // pin values for the next cycle
    logic next_done;
    logic [DATA_W-1:0] next_rd_data;
    logic [DATA_W-1:0] dq_sync; // data pins after two flops

    localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(WRITE_SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(WRITE_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_LOAD = CNT_W'(POST_WRITE_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] FLOAT_LOAD = CNT_W'(FLOAT_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CHIP_LOAD = CNT_W'(CHIP_CYCLES - 1);

    // the memory answers from outside our clock, so sample it late and synced
    eeprom_pin_sync #(
        .WIDTH(DATA_W)
    ) u_dq_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(en),
        .pin_in(dq_in),
        .pin_sync(dq_sync)
    );

    // handshake outputs straight from state
    assign cmd_ready = (state == ST_IDLE);
    assign busy = (state != ST_IDLE);

    // sequencer next values
    always_comb begin
        next_state = state;
        next_req = req;
        next_erase_phase = erase_phase;
        next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        next_done = 1'b0;
        next_rd_data = rd_data;
        case (state)
            ST_IDLE: begin
                // a single request at a time; ready is low otherwise
                if (cmd_valid) begin
                    next_req = cmd;
                    if (cmd.op == OP_READ) begin
                        next_state = ST_RD_WAIT;
                        next_cnt = READ_LOAD;
                    end else begin
                        next_state = ST_SETUP;
                        next_cnt = SETUP_LOAD;
                        // a write always starts with an erase of the byte
                        next_erase_phase = (cmd.op != OP_CHIP_ERASE);
                    end
                end
            end
            ST_SETUP: begin
                // address and select settle before the strobe falls
                if (cnt == '0) begin
                    next_state = ST_STROBE;
                    next_cnt = (req.op == OP_CHIP_ERASE) ? CHIP_LOAD : PULSE_LOAD;
                end
            end
            ST_STROBE: begin
                if (cnt == '0) begin
                    next_state = ST_HOLD;
                    next_cnt = HOLD_LOAD;
                end
            end
            ST_HOLD: begin
                // data still held after strobe rises
                if (cnt == '0) begin
                    next_state = ST_RECOVER;
                    next_cnt = WAIT_LOAD;
                end
            end
            ST_RECOVER: begin
                if (cnt == '0) begin
                    if (req.op == OP_WRITE && erase_phase) begin
                        // same sequence again, now with the real byte
                        next_erase_phase = 1'b0;
                        next_state = ST_SETUP;
                        next_cnt = SETUP_LOAD;
                    end else begin
                        next_erase_phase = 1'b0;
                        next_state = ST_IDLE;
                        next_done = 1'b1;
                    end
                end
            end
            ST_RD_WAIT: begin
                // select and gate fell together, so one access time covers both
                if (cnt == '0) begin
                    next_rd_data = dq_sync;
                    next_state = ST_RD_FLOAT;
                    next_cnt = FLOAT_LOAD;
                end
            end
            ST_RD_FLOAT: begin
                // let the memory release the bus before anyone drives it
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // pin levels follow the next state so that they come from flops
    always_comb begin
        next_pins.select_n = 1'b1;
        next_pins.gate_n = 1'b1;
        next_pins.strobe_n = 1'b1;
        next_pins.gate_high_volt = 1'b0;
        next_pins.addr = next_req.addr;
        next_pins.dq_out = next_req.data;
        next_pins.dq_oe = 1'b0;
        case (next_state)
            ST_SETUP, ST_STROBE, ST_HOLD: begin
                next_pins.select_n = 1'b0;
                next_pins.gate_n = 1'b1;
                next_pins.strobe_n = (next_state != ST_STROBE);
                next_pins.dq_oe = 1'b1;
                // erase of a byte or of the array wants all ones
                if (next_erase_phase || next_req.op == OP_CHIP_ERASE) begin
                    next_pins.dq_out = ERASED_BYTE;
                end
                next_pins.gate_high_volt = (next_req.op == OP_CHIP_ERASE);
            end
            ST_RD_WAIT: begin
                // gate low only for a read, like a bus read strobe
                next_pins.select_n = 1'b0;
                next_pins.gate_n = 1'b0;
            end
            default: begin
                // standby: select high blocks every write
                next_pins.select_n = 1'b1;
            end
        endcase
    end

    // register everything; enable low freezes it all
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            req <= '{op: OP_READ, addr: ADDR_RESET, data: DATA_RESET};
            erase_phase <= 1'b0;
            cnt <= '0;
            done <= 1'b0;
            rd_data <= DATA_RESET;
            pins <= '{select_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1, gate_high_volt: 1'b0,
                addr: ADDR_RESET, dq_out: DATA_RESET, dq_oe: 1'b0};
        end else if (en) begin
            state <= next_state;
            req <= next_req;
            erase_phase <= next_erase_phase;
            cnt <= next_cnt;
            done <= next_done;
            rd_data <= next_rd_data;
            pins <= next_pins;
        end
    end

    // helper logic for the checks below
    logic [CNT_W-1:0] strobe_len; // enabled cycles with strobe low
    logic [CNT_W-1:0] gap_len; // enabled cycles since the last strobe rose
    logic erased_ok; // an erase of the current byte has completed

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strobe_len <= '0;
            gap_len <= '1; // saturated: no write yet, so no gap is owed
            erased_ok <= 1'b0;
        end else if (en) begin
            strobe_len <= !pins.strobe_n ? strobe_len + CNT_W'(1) : '0;
            gap_len <= !pins.strobe_n ? '0 :
                (gap_len != {CNT_W{1'b1}} ? gap_len + CNT_W'(1) : gap_len);
            if (state == ST_IDLE) begin
                erased_ok <= 1'b0;
            end else if (state == ST_STROBE && next_state == ST_HOLD && erase_phase) begin
                erased_ok <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_strobe_rise;
        $rose(pins.strobe_n);
    endsequence

    sequence s_data_strobe_fall;
        $fell(pins.strobe_n) && req.op == OP_WRITE && !erase_phase;
    endsequence

    sequence s_select_fall;
        $fell(pins.select_n);
    endsequence

    a_gate_during_write: assert property (!pins.strobe_n |-> pins.gate_n)
        else $error("gate low while strobe low");

    a_erase_ones: assert property (!pins.strobe_n && (erase_phase || pins.gate_high_volt)
        |-> pins.dq_out == ERASED_BYTE && pins.dq_oe && !pins.select_n)
        else $error("erase without all ones on data");

    a_strobe_width: assert property (s_strobe_rise |-> strobe_len ==
        (req.op == OP_CHIP_ERASE ? CHIP_LOAD : PULSE_LOAD) + CNT_W'(1))
        else $error("strobe width wrong");

    a_pins_stable: assert property (!pins.strobe_n && $past(!pins.strobe_n)
        |-> $stable(pins.addr) && $stable(pins.dq_out) && $stable(pins.select_n))
        else $error("pins moved during programming");

    a_erase_first: assert property (s_data_strobe_fall |-> erased_ok)
        else $error("data write without prior erase");

    a_write_repeats: assert property (s_data_strobe_fall
        |-> pins.dq_out == req.data && pins.dq_oe)
        else $error("write strobe without stored byte");

    a_chip_data_high: assert property (pins.gate_high_volt
        |-> pins.dq_out == ERASED_BYTE && pins.dq_oe && pins.gate_n)
        else $error("chip erase without all ones");

    a_read_gate: assert property (!pins.gate_n
        |-> !pins.select_n && pins.strobe_n && !pins.dq_oe && state == ST_RD_WAIT)
        else $error("gate low outside a read");

    a_post_write_gap: assert property ((s_select_fall and $past(gap_len) != '0)
        |-> gap_len >= CNT_W'(POST_WRITE_WAIT_CYC))
        else $error("next cycle too soon after write");
endmodule

// ### tb/eeprom_dev_model.sv
`timescale 1ns/1ns
// behavioural byte memory on the far side of the host, with pin-rule watchers
module eeprom_dev_model #(
    parameter int ACC_NS = 250,  // access delay from select or address
    parameter int MIN_NS = 200,  // shortest strobe that programs
    parameter int MAX_NS = 333,  // longest strobe tolerated
    parameter int GAP_NS = 40000 // quiet time owed after a strobe
) (
    // control pins, active low except gate_high_volt
    input wire logic select_n,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic gate_high_volt,
    // address and data
    input wire logic [10:0] addr,
    input wire logic [7:0] din,
    input wire logic host_oe,
    output logic [7:0] dout,
    output logic dout_en,
    // breaches of the host-side pin rules
    output int viol
);
    logic [7:0] mem [0:2047]; // cell array
    logic rd_ok = 1'b0;       // read path settled
    logic wrote = 1'b0;       // a strobe has been seen
    time t_fall = 0;          // last strobe fall
    time t_rise = 0;          // last strobe rise
    int gen = 0;              // read restart count
    // power-up content is arbitrary but not erased
    initial begin
        viol = 0;
        for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // drives only in read mode, standby and idle float
    assign dout_en = !select_n && !gate_n && strobe_n;
    // wrong data until the access time has run, so an early sample fails
    assign dout = rd_ok ? mem[addr] : ~mem[addr];
    // every restart of a read cancels the pending valid
    always @(dout_en or addr) begin
        gen++;
        rd_ok = 1'b0;
        if (dout_en) fork
            automatic int g = gen;
            begin
                #(ACC_NS);
                if (g == gen) rd_ok = 1'b1;
            end
        join_none
    end
    always @(negedge strobe_n) t_fall = $time;
    // next cycle too soon after a strobe
    always @(negedge select_n) if (wrote && $time - t_rise < GAP_NS) viol++;
    // gate must not drop while strobing
    always @(negedge gate_n) if (!strobe_n) viol++;
    // pins moving inside the programming interval
    always @(addr or din or select_n or gate_high_volt) begin
        if (!strobe_n && $time != t_fall) viol++;
    end
    // both sides driving the data wire
    always @(host_oe or dout_en) if (host_oe && dout_en) viol++;
    // strobe end commits the operation; select high ignores it
    // a raised-voltage strobe reads as the same logic level, so both commit here
    always @(posedge strobe_n) if (!select_n) begin
        if ($time - t_fall < MIN_NS || $time - t_fall > MAX_NS || !gate_n) viol++;
        if ($time - t_fall >= MIN_NS) begin
            if (gate_high_volt) begin
                if (din !== 8'hff) viol++;
                for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
            end else if (din === 8'hff) begin
                mem[addr] = 8'hff;
            end else begin
                // bits only fall, so a write without erase corrupts the byte
                mem[addr] = mem[addr] & din;
            end
        end
        t_rise = $time;
        wrote = 1'b1;
    end
endmodule

// ### tb/test_eeprom_host.sv
`timescale 1ns/1ns
// self-checking bench for the byte access host
module test_eeprom_host;
    import eeprom_host_pkg::*;
    // clock, reset and user side
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic cmd_ready, done, busy;
    logic [DATA_W-1:0] rd_data;
    // memory side
    pins_t pins;
    logic [DATA_W-1:0] dq_in, dev_dout;
    logic [DATA_W-1:0] last_dq = 8'h00;
    logic dev_en;
    int viol;
    // expectations: one note per request, retired by done
    typedef struct { logic is_rd; logic [7:0] val; } note_t;
    note_t notes[$];
    logic [7:0] shadow [0:2047]; // expected memory content
    int n_errors = 0;
    int checks_done = 0;
    int seed = 14;
    logic jitter = 1'b0; // random enable drops, reads only

    initial forever #5 clk_sys = ~clk_sys;

    eeprom_host #(.PULSE_CYCLES(20), .CHIP_CYCLES(25)) uut (.clk_sys(clk_sys), .rst(rst),
        .en(en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .done(done),
        .rd_data(rd_data), .busy(busy), .pins(pins), .dq_in(dq_in));

    eeprom_dev_model dev (.select_n(pins.select_n), .gate_n(pins.gate_n),
        .strobe_n(pins.strobe_n), .gate_high_volt(pins.gate_high_volt), .addr(pins.addr),
        .din(dq_in), .host_oe(pins.dq_oe), .dout(dev_dout), .dout_en(dev_en), .viol(viol));

    // wire resolution; a released wire shows the inverse of its last level
    assign dq_in = pins.dq_oe ? pins.dq_out : (dev_en ? dev_dout : ~last_dq);
    always @(posedge clk_sys) if (pins.dq_oe || dev_en) last_dq <= dq_in;
    // enable drops stretch pin times, so only during reads
    always @(posedge clk_sys) en <= jitter ? ($random(seed) % 4 != 0) : 1'b1;

    task automatic fail(input string msg);
        n_errors++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one request; valid stays up so the next call may follow at once
    task automatic do_op(input op_t op, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd <= '{op: op, addr: a, data: d};
        cmd_valid <= 1'b1;
        @(negedge clk_sys);
        while (!(cmd_ready === 1'b1 && en === 1'b1)) begin
            n++;
            if (n > 20000) begin
                fail("request never taken");
                finish_test();
            end
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        notes.push_back('{op == OP_READ, shadow[a]});
        if (op == OP_CHIP_ERASE) foreach (shadow[i]) shadow[i] = 8'hff;
        else if (op != OP_READ) shadow[a] = (op == OP_ERASE) ? 8'hff : d;
    endtask

    // lower valid and wait for every answer
    task automatic drain(input string name);
        int n;
        n = 0;
        cmd_valid <= 1'b0;
        while (notes.size() != 0) begin
            n++;
            if (n > 20000) begin
                fail("answer missing");
                finish_test();
            end
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        $display("test %s done", name);
    endtask

    // each done retires the oldest note; reads compare their data
    always @(negedge clk_sys) if (done === 1'b1 && en === 1'b1) begin
        note_t nt;
        if (notes.size() == 0) begin
            fail("done without request");
        end else begin
            nt = notes.pop_front();
            if (nt.is_rd) begin
                checks_done++;
                if (rd_data !== nt.val) fail("read data");
            end
        end
    end

    initial begin
        logic [10:0] a [0:2];
        int i;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        checks_done++;
        if (!(cmd_ready === 1'b1 && busy === 1'b0 && done === 1'b0 && rd_data === 8'h00))
            fail("user side after reset");
        checks_done++;
        if (!(pins.select_n === 1'b1 && pins.strobe_n === 1'b1 && pins.dq_oe === 1'b0))
            fail("pins after reset");
        @(posedge clk_sys);
        // whole-array erase, then back-to-back reads
        do_op(OP_CHIP_ERASE, 11'h000, 8'h00);
        for (i = 0; i < 4; i++) do_op(OP_READ, 11'($random(seed)), 8'h00);
        drain("chip erase");
        // writes, the top address among them
        a[0] = 11'($random(seed));
        a[1] = a[0] + 11'h001;
        a[2] = 11'h7ff;
        for (i = 0; i < 3; i++) do_op(OP_WRITE, a[i], 8'($random(seed)));
        drain("write");
        // read back with enable drops stretching the read
        jitter <= 1'b1;
        for (i = 0; i < 3; i++) do_op(OP_READ, a[i], 8'h00);
        do_op(OP_READ, 11'h7fe, 8'h00);
        drain("read back");
        jitter <= 1'b0;
        // single-byte erase leaves the neighbour alone
        do_op(OP_ERASE, a[0], 8'h00);
        do_op(OP_READ, a[0], 8'h00);
        do_op(OP_READ, a[1], 8'h00);
        drain("byte erase");
        checks_done++;
        if (viol != 0) fail("memory pin timing");
        finish_test();
    end
endmodule
